// File: core/sdr_scan_path.sv
`timescale 1ns/1ns
// Summary of operation
// - Bypass loads zero leaving Capture-DR
// - Enable output on falling edge into Shift-DR
// - Bypass shift: output lags input by one
// - Release output on falling edge in Exit1-DR
// - Update-DR falling edge loads the wide register unless bypass is selected
// - Sample rising edges, drive output on falling
// - All-ones instruction selects bypass register
module sdr_scan_path
    import sdr_pkg::*;
(
    input  wire logic                i_mclk,
    input  wire logic                i_reset_n,
    input  wire logic                i_tck,
    input  wire logic                i_tms,
    input  wire logic                i_tdi,
    output logic                     o_tdo,
    output logic                     o_tdo_oe,
    output logic                     o_bypass_sel,
    output logic [SDR_DR_W-1:0]      o_dr_value
);

    // ==========================================================
    // Pin synchronisers and edge detection
    // ==========================================================
    sdr_pins_t              pins_s1;   // First stage, read only by second
    sdr_pins_t              pins_s2;   // Second stage, safe to use
    logic                   tck_d;     // Delayed test clock for edges
    logic                   tck_rise;  // One-cycle strobe on a rising edge
    logic                   tck_fall;  // One-cycle strobe on a falling edge
    sdr_state_t             state;     // Controller state
    sdr_state_t             next_state;
    logic [SDR_IR_W-1:0]    ir_sr;     // Instruction shift stage
    logic [SDR_IR_W-1:0]    ir;        // Active instruction
    logic                   bypass;    // One-bit bypass register
    logic [SDR_DR_W-1:0]    dr_sr;     // Shift stage of the wide data register

    // Two flops on every pin; the link clock is just another input
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            pins_s1 <= '0;
            pins_s2 <= '0;
            tck_d   <= 1'b0;
        end else begin
            pins_s1 <= sdr_pins_t'({i_tck, i_tms, i_tdi});
            pins_s2 <= pins_s1;
            tck_d   <= pins_s2.tck;
        end
    end

    assign tck_rise = pins_s2.tck & ~tck_d;
    assign tck_fall = ~pins_s2.tck & tck_d;

    // ==========================================================
    // Controller state machine
    // ==========================================================
    // Next state from mode select, standard sixteen-state walk
    always_comb begin
        next_state = state;
        case (state)
            SDR_TLR:      next_state = pins_s2.tms ? SDR_TLR      : SDR_RTI;
            SDR_RTI:      next_state = pins_s2.tms ? SDR_SEL_DR   : SDR_RTI;
            SDR_SEL_DR:   next_state = pins_s2.tms ? SDR_SEL_IR   : SDR_CAP_DR;
            SDR_CAP_DR:   next_state = pins_s2.tms ? SDR_EXIT1_DR : SDR_SHIFT_DR;
            SDR_SHIFT_DR: next_state = pins_s2.tms ? SDR_EXIT1_DR : SDR_SHIFT_DR;
            SDR_EXIT1_DR: next_state = pins_s2.tms ? SDR_UPD_DR   : SDR_PAUSE_DR;
            SDR_PAUSE_DR: next_state = pins_s2.tms ? SDR_EXIT2_DR : SDR_PAUSE_DR;
            SDR_EXIT2_DR: next_state = pins_s2.tms ? SDR_UPD_DR   : SDR_SHIFT_DR;
            SDR_UPD_DR:   next_state = pins_s2.tms ? SDR_SEL_DR   : SDR_RTI;
            SDR_SEL_IR:   next_state = pins_s2.tms ? SDR_TLR      : SDR_CAP_IR;
            SDR_CAP_IR:   next_state = pins_s2.tms ? SDR_EXIT1_IR : SDR_SHIFT_IR;
            SDR_SHIFT_IR: next_state = pins_s2.tms ? SDR_EXIT1_IR : SDR_SHIFT_IR;
            SDR_EXIT1_IR: next_state = pins_s2.tms ? SDR_UPD_IR   : SDR_PAUSE_IR;
            SDR_PAUSE_IR: next_state = pins_s2.tms ? SDR_EXIT2_IR : SDR_PAUSE_IR;
            SDR_EXIT2_IR: next_state = pins_s2.tms ? SDR_UPD_IR   : SDR_SHIFT_IR;
            SDR_UPD_IR:   next_state = pins_s2.tms ? SDR_SEL_DR   : SDR_RTI;
            default:      next_state = SDR_TLR;
        endcase
    end

    // Advance only on a rising test-clock edge; mode select was set up
    // by the controller on the falling edge before it
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            state <= SDR_TLR;
        end else if (tck_rise) begin
            state <= next_state;
        end
    end

    // ==========================================================
    // Instruction register
    // ==========================================================
    // Shift stage works on rising edges, active copy on falling edges
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            ir_sr <= SDR_IR_CAPTURE;
            ir    <= SDR_IR_BYPASS;
        end else begin
            if (tck_rise && state == SDR_CAP_IR) begin
                ir_sr <= SDR_IR_CAPTURE;
            end else if (tck_rise && state == SDR_SHIFT_IR) begin
                ir_sr <= {pins_s2.tdi, ir_sr[SDR_IR_W-1:1]};
            end
            if (tck_fall && state == SDR_UPD_IR) begin
                ir <= ir_sr;
            end else if (tck_fall && state == SDR_TLR) begin
                // Reset leaves bypass selected so a blind scan is harmless
                ir <= SDR_IR_BYPASS;
            end
        end
    end

    // Bypass choice held in a flop so it can be an output directly
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_bypass_sel <= 1'b1;
        end else begin
            o_bypass_sel <= (ir == SDR_IR_BYPASS);
        end
    end

    // ==========================================================
    // Data registers
    // ==========================================================
    // Bypass: zero on capture, one stage of delay while shifting
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            bypass <= SDR_BYP_CAPT;
        end else if (tck_rise && state == SDR_CAP_DR) begin
            bypass <= SDR_BYP_CAPT;
        end else if (tck_rise && state == SDR_SHIFT_DR) begin
            bypass <= pins_s2.tdi;
        end
    end

    // Wide register for every other opcode; capture reflects the last update
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            dr_sr      <= SDR_DR_RESET;
            o_dr_value <= SDR_DR_RESET;
        end else begin
            if (tck_rise && state == SDR_CAP_DR) begin
                dr_sr <= o_dr_value;
            end else if (tck_rise && state == SDR_SHIFT_DR) begin
                dr_sr <= {pins_s2.tdi, dr_sr[SDR_DR_W-1:1]};
            end
            // Bypass has nothing behind it, so only the wide one updates
            if (tck_fall && state == SDR_UPD_DR && !o_bypass_sel) begin
                o_dr_value <= dr_sr;
            end
        end
    end

    // ==========================================================
    // Serial output
    // ==========================================================
    // Driven and released only on falling edges, from the selected stage
    always_ff @(posedge i_mclk) begin
        if (!i_reset_n) begin
            o_tdo    <= 1'b0;
            o_tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            case (state)
                SDR_SHIFT_DR: begin
                    o_tdo    <= o_bypass_sel ? bypass : dr_sr[0];
                    o_tdo_oe <= 1'b1;
                end
                SDR_SHIFT_IR: begin
                    o_tdo    <= ir_sr[0];
                    o_tdo_oe <= 1'b1;
                end
                SDR_EXIT1_DR, SDR_EXIT1_IR: begin
                    o_tdo_oe <= 1'b0;
                end
                default: begin
                    // Pause and other states keep the line released
                    o_tdo_oe <= 1'b0;
                end
            endcase
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_rise_tms_hi;
        tck_rise && pins_s2.tms;
    endsequence

    sequence s_fall_in(sdr_state_t st);
        tck_fall && state == st;
    endsequence

    AST_CAPTURE_ZERO: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        tck_rise && state == SDR_CAP_DR |=> bypass == 1'b0 && state != SDR_CAP_DR)
        else $error("bypass did not capture zero");

    AST_SHIFT_ENABLE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        s_fall_in(SDR_SHIFT_DR) |=> o_tdo_oe)
        else $error("output not enabled in shift");

    AST_BYPASS_LAG: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        tck_rise && state == SDR_SHIFT_DR && o_bypass_sel
        |=> bypass == $past(pins_s2.tdi))
        else $error("bypass stage lost input bit");

    AST_BYPASS_OUT: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        s_fall_in(SDR_SHIFT_DR) && o_bypass_sel |=> o_tdo == $past(bypass))
        else $error("output not fed from bypass");

    AST_EXIT_RELEASE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        s_fall_in(SDR_EXIT1_DR) |=> !o_tdo_oe)
        else $error("output not released in exit1");

    AST_UPDATE_DR: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        s_fall_in(SDR_UPD_DR) && !o_bypass_sel |=> o_dr_value == $past(dr_sr))
        else $error("data register not updated");

    AST_TDO_ON_FALL: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !tck_fall |=> $stable(o_tdo) && $stable(o_tdo_oe))
        else $error("serial output moved off a falling edge");

    AST_STATE_ON_RISE: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        !tck_rise |=> $stable(state))
        else $error("state moved off a rising edge");

    AST_SELECT_BYPASS: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        s_fall_in(SDR_UPD_IR) && ir_sr == SDR_IR_BYPASS |=> ##1 o_bypass_sel)
        else $error("all-ones opcode did not select bypass");

    AST_RESET_PATH: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state == SDR_UPD_DR ##0 s_rise_tms_hi |=> state == SDR_SEL_DR)
        else $error("update-dr did not step to select-dr");

    AST_RESET_END: assert property (@(posedge i_mclk) disable iff (!i_reset_n)
        state == SDR_SEL_IR ##0 s_rise_tms_hi |=> state == SDR_TLR)
        else $error("select-ir did not step to reset");

endmodule

// File: core/sdr_pkg.sv
package sdr_pkg;

    // ==========================================================
    // Scan port widths and codes
    // ==========================================================
    localparam int          SDR_IR_W       = 8;        // Instruction register width
    localparam int          SDR_DR_W       = 8;        // Width of the non-bypass data register
    localparam logic [7:0]  SDR_IR_CAPTURE = 8'h81;    // Pattern loaded in Capture-IR
    localparam logic [7:0]  SDR_IR_BYPASS  = 8'hff;    // All-ones opcode selects bypass
    localparam logic        SDR_BYP_CAPT   = 1'h0;     // Bypass capture value
    localparam logic [7:0]  SDR_DR_RESET   = 8'h00;    // Reset value of the data register

    // ==========================================================
    // Controller states
    // ==========================================================
    typedef enum logic [3:0] {
        SDR_TLR, SDR_RTI,
        SDR_SEL_DR, SDR_CAP_DR, SDR_SHIFT_DR, SDR_EXIT1_DR,
        SDR_PAUSE_DR, SDR_EXIT2_DR, SDR_UPD_DR,
        SDR_SEL_IR, SDR_CAP_IR, SDR_SHIFT_IR, SDR_EXIT1_IR,
        SDR_PAUSE_IR, SDR_EXIT2_IR, SDR_UPD_IR
    } sdr_state_t;

    // Scan pins that travel together through the synchroniser
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } sdr_pins_t;

endpackage

// File: verif/sdr_ctl_model.sv
`timescale 1ns/1ns
// ==========================================================
// Scan controller model: frames of test clocks, eight system clocks each
// ==========================================================
module sdr_ctl_model (
    input  wire logic i_mclk,
    input  wire logic i_tdo_w,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi
);
    // Test clock stands low outside frames
    initial begin
        o_tck = 1'h0;
        o_tms = 1'h1;
        o_tdi = 1'h0;
    end

    // One test clock: mode and data change as the clock falls, held through the rise
    task automatic step(input logic tms, input logic tdi, output logic tdo);
        @(posedge i_mclk);
        o_tck <= 1'h0;
        o_tms <= tms;
        o_tdi <= tdi;
        repeat (4) @(posedge i_mclk);
        o_tck <= 1'h1;
        // Sample midway through the high phase, well after the output settled
        repeat (2) @(posedge i_mclk);
        tdo = i_tdo_w;
        // One more edge here; the next call's first wait closes a 320 ns period
        @(posedge i_mclk);
    endtask

    // End of frame: clock parked low, input data line flips so stale bits never match
    task automatic idle();
        @(posedge i_mclk);
        o_tck <= 1'h0;
        repeat (8) @(posedge i_mclk);
        o_tdi <= ~o_tdi;
    endtask
endmodule

// File: verif/sdr_scan_path_bench.sv
`timescale 1ns/1ns
// ==========================================================
// Bench: queue model of the scan path against the design
// ==========================================================
module sdr_scan_path_bench;
    import sdr_pkg::*;
    logic                mclk;        // System clock
    logic                reset_n;     // Synchronous reset, active low
    logic                tck;         // Test clock from the controller
    logic                tms;         // Mode select
    logic                tdi;         // Serial input
    logic                tdo;         // Serial output data
    logic                tdo_oe;      // Serial output enable
    logic                bypass_sel;  // Bypass instruction active
    logic [SDR_DR_W-1:0] dr_value;    // Wide data register
    wire logic           tdo_w = tdo_oe ? tdo : 1'bz;  // Resolved serial pin
    int                  num_errors;  // Mismatches
    int                  n_tests;     // Comparisons made
    logic [7:0]          exp_ir;      // Model instruction
    logic [7:0]          exp_dr;      // Model wide register
    logic                at_tlr;      // Model sits in Test-Logic-Reset
    logic [7:0]          op;          // Random non-bypass opcode
    int                  i;

    initial mclk = 1'h0;
    always #20 mclk = ~mclk;

    sdr_scan_path dut (.i_mclk(mclk), .i_reset_n(reset_n), .i_tck(tck), .i_tms(tms),
        .i_tdi(tdi), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_bypass_sel(bypass_sel),
        .o_dr_value(dr_value));
    sdr_ctl_model ctl (.i_mclk(mclk), .i_tdo_w(tdo_w), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));

    // ==========================================================
    // Compare and report
    // ==========================================================
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        $display("errors=%0d compares=%0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Reset held 12 cycles; model returns to its reset picture
    task automatic do_reset();
        @(posedge mclk);
        reset_n <= 1'h0;
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (2) @(posedge mclk);
        exp_ir = SDR_IR_BYPASS;
        exp_dr = SDR_DR_RESET;
        at_tlr = 1'h1;
        check(tdo_w, 1'bz);
        check(bypass_sel, 1'h1);
        check(dr_value, exp_dr);
    endtask

    // ==========================================================
    // One scan: queue holds the captured bits, each shift pops one and pushes tdi
    // ==========================================================
    task automatic scan(input logic ir, input int n, input logic [7:0] din, input logic to_tlr);
        logic q[$];
        logic t;
        int   k;
        if (at_tlr) ctl.step(1'h0, 1'h0, t);
        ctl.step(1'h1, 1'h0, t);
        if (ir) ctl.step(1'h1, 1'h0, t);
        ctl.step(1'h0, 1'h0, t);
        ctl.step(1'h0, 1'h0, t);
        check(t, 1'bz);
        if (ir) for (k = 0; k < 8; k++) q.push_back(SDR_IR_CAPTURE[k]);
        else if (exp_ir == SDR_IR_BYPASS) q.push_back(SDR_BYP_CAPT);
        else for (k = 0; k < 8; k++) q.push_back(exp_dr[k]);
        for (k = 0; k < n; k++) begin
            ctl.step(k == n - 1, din[k], t);
            check(t, q.pop_front());
            q.push_back(din[k]);
        end
        ctl.step(1'h1, 1'h0, t);
        check(t, 1'bz);
        // Bypass keeps the wide register untouched; a short queue never reaches it
        if (ir) for (k = 0; k < 8; k++) exp_ir[k] = q[k];
        else if (exp_ir != SDR_IR_BYPASS) for (k = 0; k < 8; k++) exp_dr[k] = q[k];
        if (to_tlr) begin
            repeat (3) ctl.step(1'h1, 1'h0, t);
            exp_ir = SDR_IR_BYPASS;
        end else begin
            ctl.step(1'h0, 1'h0, t);
        end
        ctl.idle();
        at_tlr = to_tlr;
        check(bypass_sel, exp_ir == SDR_IR_BYPASS);
        check(dr_value, exp_dr);
    endtask

    // ==========================================================
    // Main sequence and watchdog
    // ==========================================================
    initial begin
        reset_n = 1'h0;
        num_errors = 0;
        n_tests = 0;
        void'($urandom(91));
        do_reset();
        scan(1'h0, 8, 8'($urandom()), 1'h1);
        scan(1'h0, 3, 8'h05, 1'h0);
        op = 8'($urandom());
        if (op == SDR_IR_BYPASS) op = 8'h0f;
        scan(1'h1, 8, op, 1'h0);
        for (i = 0; i < 3; i++) begin
            scan(1'h0, 8, 8'($urandom()), i == 2);
        end
        scan(1'h1, 8, SDR_IR_BYPASS, 1'h0);
        scan(1'h0, 5, 8'($urandom()), 1'h0);
        scan(1'h1, 8, op, 1'h0);
        scan(1'h0, 8, 8'($urandom()), 1'h0);
        do_reset();
        end_sim();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (50000) @(posedge mclk);
        num_errors++;
        end_sim();
    end
endmodule
